// ### ppe_port.sv
// Parallel printer port with enhanced-mode cycles behind an APB slave
//
// Operation
// - Four modes, eight-bit parallel data
// - Four address bits decode eleven registers
// - Enhanced ports answer only in enhanced mode
// - Data read returns printer-side data latch
// - Offset 2 writes latch, reads it back
// - Readback: ones above, five control bits
// - Control latch bit map, turnaround bit 5
// - Enhanced ports map straight onto lines
// - Status shows live inputs, bits 2-1 one
// - Timeout flag set, cleared by writing one
// - Enhanced mode remaps the pin roles
// - Watchdog aborts enhanced cycle after 10 us
// - Cycle starts only while wait is low
// - Turnaround bit sets direction, zero in standard
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps

module ppe_port #(
  parameter int ADDR_W = 6  // APB byte address width
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Interrupt
  output logic                   irq,
  // Parallel data lines, two-way
  input  wire logic [7:0]        parallel_data_lines_i,
  output logic      [7:0]        parallel_data_lines_o,
  output logic                   parallel_data_lines_oe,
  // Control pins to the peripheral
  output logic                   strobe_pin_n,
  output logic                   feed_pin_n,
  output logic                   select_pin_n,
  output logic                   reinit_pin_n,
  // Status pins from the peripheral
  input  wire logic              busy_pin,
  input  wire logic              ack_pin_n,
  input  wire logic              paper_out,
  input  wire logic              printer_online,
  input  wire logic              fault_pin_n
);

  localparam int SYNC_W = 13;  // Five status pins plus eight data lines
  localparam logic [7:0] WDOG_LIM = 8'(ppe_pkg::WDOG_CYCLES);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DONE,
    ST_EPP_WAIT,
    ST_EPP_STROBE
  } ppe_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [SYNC_W-1:0] sync1_reg;  // First stage, read by second stage only
  logic [SYNC_W-1:0] sync2_reg;  // Safe copy
  logic              ack_dly_reg; // Previous safe acknowledge

  // Two flops on every pin that comes from the peripheral
  always_ff @(posedge clk) begin
    if (rst) begin
      // Idle pin levels, so no false acknowledge edge follows reset
      sync1_reg   <= ppe_pkg::SYNC_RESET;
      sync2_reg   <= ppe_pkg::SYNC_RESET;
      ack_dly_reg <= 1'b1;
    end else begin
      sync1_reg   <= {busy_pin, ack_pin_n, paper_out, printer_online, fault_pin_n,
                      parallel_data_lines_i};
      sync2_reg   <= sync1_reg;
      ack_dly_reg <= sync2_reg[11];
    end
  end

  logic       busy_s;       // Busy, also the wait line in enhanced mode
  logic       ack_s;        // Acknowledge, also the interrupt line
  logic [4:0] pins_s;       // Live status pins in buffer order
  logic [7:0] lines_s;      // Data lines as seen from outside
  logic       peripheral_hold_n;
  assign pins_s  = sync2_reg[12:8];
  assign lines_s = sync2_reg[7:0];
  assign busy_s  = sync2_reg[12];
  assign ack_s   = sync2_reg[11];
  assign peripheral_hold_n = busy_s;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [3:0] idx;          // Register index
  logic       access;       // Access phase awaiting an answer
  logic       is_epp_off;   // Offset 3..7
  logic       mapped;       // Any implemented register
  assign idx        = paddr[5:2];
  assign is_epp_off = (idx >= ppe_pkg::IDX_EADDR) && (idx <= 4'h7);
  assign mapped     = (idx <= 4'h7) || (idx == ppe_pkg::IDX_MODE) ||
                      (idx == ppe_pkg::IDX_IRQ_STAT) || (idx == ppe_pkg::IDX_IRQ_MASK);

  typedef ppe_pkg::ppe_mode_t ppe_mode_t;  // Local alias for mode casts

  ppe_state_t        state_reg;
  logic [1:0]        mode_reg;      // Selected operating mode
  logic [7:0]        ctl_reg;       // Control latch
  logic [7:0]        data_reg;      // Printer-side data latch
  logic [7:0]        eport_reg [5]; // Address port and four data ports
  logic              bus_timeout_flag_reg;     // Sticky watchdog flag
  logic [ppe_pkg::EV_W-1:0] ev_reg;   // Sticky events
  logic [ppe_pkg::EV_W-1:0] mask_reg; // Event mask
  logic [7:0]        wdog_reg;      // Watchdog cycle count
  logic              cyc_rd_reg;    // Current cycle is a read
  logic              cyc_addr_reg;  // Current cycle uses the address strobe
  logic [2:0]        cyc_port_reg;  // Which enhanced port
  logic              epp_mode;
  logic              std_mode;
  assign epp_mode = (ppe_mode_t'(mode_reg) == ppe_pkg::enhanced_mode);
  assign std_mode = (ppe_mode_t'(mode_reg) == ppe_pkg::standard_mode);
  assign access   = psel && penable && (state_reg == ST_IDLE);

  logic wr_hit;             // Plain register write this cycle
  assign wr_hit = access && pwrite && mapped && !is_epp_off;

  logic wdog_hit;           // Watchdog expiry this cycle
  assign wdog_hit = ((state_reg == ST_EPP_WAIT) || (state_reg == ST_EPP_STROBE)) &&
                    (wdog_reg == WDOG_LIM - 8'h01);

  logic cyc_done;           // Peripheral released wait, cycle complete
  assign cyc_done = (state_reg == ST_EPP_STROBE) && peripheral_hold_n && !wdog_hit;

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      ppe_pkg::IDX_DATA:     rd_byte = data_reg;
      ppe_pkg::IDX_STATUS:   rd_byte = {pins_s, 3'b000} | ppe_pkg::STS_ONES |
                                       {7'h00, bus_timeout_flag_reg};
      ppe_pkg::IDX_CONTROL:  rd_byte = ppe_pkg::RB_ONES | {3'b000, ctl_reg[4:0]};
      ppe_pkg::IDX_MODE:     rd_byte = {6'h00, mode_reg};
      ppe_pkg::IDX_IRQ_STAT: rd_byte = {5'h00, ev_reg};
      ppe_pkg::IDX_IRQ_MASK: rd_byte = {5'h00, mask_reg};
      default:               rd_byte = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus and enhanced cycle sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= 32'h0000_0000;
      wdog_reg     <= 8'h00;
      cyc_rd_reg   <= 1'b0;
      cyc_addr_reg <= 1'b0;
      cyc_port_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (access) begin
            if (is_epp_off && epp_mode) begin
              // Enhanced port: run a cycle on the pins first
              state_reg    <= ST_EPP_WAIT;
              wdog_reg     <= 8'h00;
              cyc_rd_reg   <= !pwrite;
              cyc_addr_reg <= (idx == ppe_pkg::IDX_EADDR);
              cyc_port_reg <= 3'(idx - ppe_pkg::IDX_EADDR);
            end else begin
              // Refuse enhanced ports outside enhanced mode and holes
              state_reg <= ST_DONE;
              pready    <= 1'b1;
              pslverr   <= is_epp_off || !mapped;
              prdata    <= (pwrite || is_epp_off) ? 32'h0000_0000 : {24'h000000, rd_byte};
            end
          end
        end
        ST_EPP_WAIT, ST_EPP_STROBE: begin
          wdog_reg <= wdog_reg + 8'h01;
          if (wdog_hit) begin
            // Abort: release strobes, answer with an error
            state_reg <= ST_DONE;
            pready    <= 1'b1;
            pslverr   <= 1'b1;
            prdata    <= 32'h0000_0000;
          end else if (state_reg == ST_EPP_WAIT) begin
            // Start only while the peripheral holds wait low
            if (!peripheral_hold_n) begin
              state_reg <= ST_EPP_STROBE;
            end
          end else if (cyc_done) begin
            state_reg <= ST_DONE;
            pready    <= 1'b1;
            prdata    <= cyc_rd_reg ? {24'h000000, lines_s} : 32'h0000_0000;
          end
        end
        ST_DONE: begin
          // Answer stands one cycle, then back to idle
          state_reg <= ST_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
        default: begin
          state_reg <= ST_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= ppe_pkg::MODE_RESET;
      ctl_reg  <= ppe_pkg::CTL_RESET;
      data_reg <= ppe_pkg::DATA_RESET;
      mask_reg <= '0;
    end else begin
      if (wr_hit && idx == ppe_pkg::IDX_DATA) begin
        data_reg <= pwdata[7:0];
      end
      if (wr_hit && idx == ppe_pkg::IDX_CONTROL) begin
        ctl_reg <= pwdata[7:0];
        if (std_mode) begin
          ctl_reg[ppe_pkg::CTL_DIR] <= 1'b0;
        end
      end else if (std_mode) begin
        // Turnaround ignored and held low in standard mode
        ctl_reg[ppe_pkg::CTL_DIR] <= 1'b0;
      end
      if (wr_hit && idx == ppe_pkg::IDX_MODE) begin
        mode_reg <= pwdata[1:0];
      end
      if (wr_hit && idx == ppe_pkg::IDX_IRQ_MASK) begin
        mask_reg <= pwdata[ppe_pkg::EV_W-1:0];
      end
    end
  end

  // Enhanced port contents: last byte written or read back
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 5; i++) begin
        eport_reg[i] <= 8'h00;
      end
    end else if (access && pwrite && is_epp_off && epp_mode) begin
      eport_reg[3'(idx - ppe_pkg::IDX_EADDR)] <= pwdata[7:0];
    end else if (cyc_done && cyc_rd_reg) begin
      eport_reg[cyc_port_reg] <= lines_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timeout flag and interrupt events; a set wins over a same-cycle clear
  logic [ppe_pkg::EV_W-1:0] ev_set;
  assign ev_set = {cyc_done, wdog_hit, ack_s && !ack_dly_reg && ctl_reg[ppe_pkg::CTL_IRQON]};

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_timeout_flag_reg <= 1'b0;
      ev_reg    <= '0;
      irq       <= 1'b0;
    end else begin
      if (wdog_hit) begin
        bus_timeout_flag_reg <= 1'b1;
      end else if (wr_hit && idx == ppe_pkg::IDX_STATUS && pwdata[ppe_pkg::STS_BUS_TIMEOUT_FLAG]) begin
        bus_timeout_flag_reg <= 1'b0;
      end
      if (wr_hit && idx == ppe_pkg::IDX_IRQ_STAT) begin
        ev_reg <= (ev_reg & ~pwdata[ppe_pkg::EV_W-1:0]) | ev_set;
      end else begin
        ev_reg <= ev_reg | ev_set;
      end
      irq <= |(ev_reg & mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drivers; enhanced cycles take over strobe, feed and select
  always_ff @(posedge clk) begin
    if (rst) begin
      strobe_pin_n           <= 1'b1;
      feed_pin_n             <= 1'b1;
      select_pin_n           <= 1'b1;
      reinit_pin_n           <= 1'b1;
      parallel_data_lines_o  <= 8'h00;
      parallel_data_lines_oe <= 1'b0;
    end else begin
      reinit_pin_n <= ctl_reg[ppe_pkg::CTL_INIT];
      if (state_reg == ST_EPP_STROBE && !wdog_hit && !cyc_done ||
          state_reg == ST_EPP_WAIT && !peripheral_hold_n && !wdog_hit) begin
        strobe_pin_n           <= cyc_rd_reg;
        feed_pin_n             <= cyc_addr_reg;
        select_pin_n           <= !cyc_addr_reg;
        parallel_data_lines_o  <= eport_reg[cyc_port_reg];
        parallel_data_lines_oe <= !cyc_rd_reg;
      end else begin
        // Idle pins follow the control and data latches
        strobe_pin_n           <= !ctl_reg[ppe_pkg::CTL_STROBE];
        feed_pin_n             <= !ctl_reg[ppe_pkg::CTL_AUTO_LINE_FEED_N];
        select_pin_n           <= !ctl_reg[ppe_pkg::CTL_SELIN];
        parallel_data_lines_o  <= data_reg;
        parallel_data_lines_oe <= std_mode || !ctl_reg[ppe_pkg::CTL_DIR];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  status_ones_a: assert property (@(posedge clk) disable iff (rst)
    pready && !pwrite && idx == ppe_pkg::IDX_STATUS && !pslverr |-> prdata[2:1] == 2'b11)
    else $error("status bits 2..1 not one");

  readback_a: assert property (@(posedge clk) disable iff (rst)
    pready && !pwrite && idx == ppe_pkg::IDX_CONTROL |-> prdata[7:0] == {3'b111, ctl_reg[4:0]})
    else $error("control readback wrong");

  dir_std_a: assert property (@(posedge clk) disable iff (rst)
    std_mode && $past(std_mode) |-> !ctl_reg[ppe_pkg::CTL_DIR])
    else $error("turnaround set in standard mode");

  epp_refuse_a: assert property (@(posedge clk) disable iff (rst)
    access && is_epp_off && !epp_mode |=> pready && pslverr)
    else $error("enhanced port answered outside enhanced mode");

  wait_start_a: assert property (@(posedge clk) disable iff (rst)
    $rose(state_reg == ST_EPP_STROBE) |-> !$past(peripheral_hold_n))
    else $error("cycle started while wait high");

  wdog_abort_a: assert property (@(posedge clk) disable iff (rst)
    $rose(state_reg == ST_EPP_WAIT) |-> ##[1:200] (state_reg == ST_DONE))
    else $error("enhanced cycle not ended by watchdog");

  bus_timeout_flag_set_a: assert property (@(posedge clk) disable iff (rst)
    wdog_hit |=> bus_timeout_flag_reg && pslverr)
    else $error("timeout flag not set");

  bus_timeout_flag_clr_a: assert property (@(posedge clk) disable iff (rst)
    wr_hit && idx == ppe_pkg::IDX_STATUS && !pwdata[0] && bus_timeout_flag_reg |=> bus_timeout_flag_reg)
    else $error("writing zero cleared timeout");

  irq_level_a: assert property (@(posedge clk) disable iff (rst)
    |(ev_reg & mask_reg) |=> irq)
    else $error("interrupt not raised");

  irq_clear_a: assert property (@(posedge clk) disable iff (rst)
    !(|(ev_reg & mask_reg)) |=> !irq)
    else $error("interrupt stuck high");

  pready_pulse_a: assert property (@(posedge clk) disable iff (rst)
    pready |=> !pready)
    else $error("bus answer stood over one cycle");

  ack_event_a: assert property (@(posedge clk) disable iff (rst)
    ack_s && !ack_dly_reg && ctl_reg[ppe_pkg::CTL_IRQON] |=> ev_reg[ppe_pkg::EV_ACK])
    else $error("acknowledge event lost");

endmodule

// ### ppe_pkg.sv
// Shared constants for the parallel printer port register block
package ppe_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_DATA     = 4'h0;  // Parallel data
  localparam logic [3:0] IDX_STATUS   = 4'h1;  // Printer status
  localparam logic [3:0] IDX_CONTROL  = 4'h2;  // Control write / readback
  localparam logic [3:0] IDX_EADDR    = 4'h3;  // Enhanced address port
  localparam logic [3:0] IDX_EDATA0   = 4'h4;  // First enhanced data port
  localparam logic [3:0] IDX_MODE     = 4'h8;  // Mode select
  localparam logic [3:0] IDX_IRQ_STAT = 4'h9;  // Sticky event status
  localparam logic [3:0] IDX_IRQ_MASK = 4'ha;  // Event mask

  // Control latch fields
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTO_LINE_FEED_N = 1;
  localparam int CTL_INIT   = 2;
  localparam int CTL_SELIN  = 3;
  localparam int CTL_IRQON  = 4;
  localparam int CTL_DIR    = 5;

  // Status buffer fields
  localparam int STS_BUS_TIMEOUT_FLAG  = 0;

  // Event bits in the interrupt status and mask registers
  localparam int EV_ACK     = 0;  // Acknowledge rising edge
  localparam int EV_BUS_TIMEOUT_FLAG   = 1;  // Enhanced cycle watchdog expired
  localparam int EV_DONE    = 2;  // Enhanced cycle completed
  localparam int EV_W       = 3;

  // Reset values and forced-high bit masks
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [1:0] MODE_RESET  = 2'h0;
  localparam logic [7:0] RB_ONES     = 8'he0;  // Readback bits 7..5 forced high
  localparam logic [7:0] STS_ONES    = 8'h06;  // Status bits 2..1 forced high
  localparam logic [12:0] SYNC_RESET = 13'h0900; // Acknowledge and fault pins idle high

  // Watchdog timing: 10 us at a 50 ns clock period
  localparam int CLK_PERIOD_NS  = 50;
  localparam int WDOG_TIME_NS   = 10000;
  localparam int WDOG_CYCLES    = WDOG_TIME_NS / CLK_PERIOD_NS;

  // Port operating modes
  typedef enum logic [1:0] {
    standard_mode,
    bidirectional_mode,
    enhanced_mode,
    extended_capability_mode
  } ppe_mode_t;

endpackage

// ### ppe_periph.sv
// Behavioural parallel peripheral facing the printer port
`timescale 1ns/1ps

module ppe_periph (
  // Clock
  input  wire logic       clk,
  // Bench controls
  input  wire logic       stall,       // Never answer enhanced cycles
  input  wire logic       force_busy,  // Hold busy whatever the cycle
  input  wire logic [3:0] dly,         // Cycles before raising wait
  input  wire logic [7:0] rd_byte,     // Byte returned on reads
  input  wire logic [3:0] sts,         // Ack, paper, online, fault
  // Port side
  input  wire logic       strobe_pin_n,
  input  wire logic       feed_pin_n,
  input  wire logic       select_pin_n,
  input  wire logic [7:0] lines_o,
  input  wire logic       lines_oe,
  output logic            busy_pin,
  output logic            ack_pin_n,
  output logic            paper_out,
  output logic            printer_online,
  output logic            fault_pin_n,
  output logic [7:0]      lines_i,
  output logic [7:0]      wr_seen
);
  logic       hs = 1'b0;    // Wait level of the handshake
  logic [3:0] cnt = 4'h0;   // Answer delay count
  logic [7:0] last = 8'h00; // Last level on the lines
  logic       strb;         // A phase strobe is active
  logic       drv;          // Peripheral drives the lines

  assign strb = !feed_pin_n || !select_pin_n;
  assign drv = strb && strobe_pin_n && !lines_oe;
  // Undriven lines toggle so a stale byte never reads as good
  assign lines_i = lines_oe ? lines_o : (drv ? rd_byte : ~last);
  assign busy_pin = force_busy | hs;
  assign {ack_pin_n, paper_out, printer_online, fault_pin_n} = sts;

  ////////////////////////////////////////////////////////////////
  // Wait rises after the delay, drops once both strobes release
  always @(posedge clk) begin
    last <= lines_i;
    if (!strb) begin
      hs  <= 1'b0;
      cnt <= 4'h0;
    end else if (!stall && !hs) begin
      cnt <= cnt + 4'h1;
      if (cnt >= dly) begin
        hs <= 1'b1;
        if (!strobe_pin_n) wr_seen <= lines_i;
      end
    end
  end
endmodule

// ### ppe_port_tb.sv
// Self-checking bench for the parallel printer port block
`timescale 1ns/1ps

module ppe_port_tb;
  // APB master and outputs
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [5:0]  paddr = 6'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq;
  // Pins
  logic [7:0]  lines_i, lines_o, wr_seen;
  logic        oe, strobe_n, feed_n, select_n, reinit_n;
  logic        busy, ack_n, paper, online, fault_n;
  // Peripheral controls
  logic        stall = 1'b0;
  logic        force_busy = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic [7:0]  rd_byte = 8'h00;
  logic [3:0]  sts = 4'hb;
  // Scoring: notes hold check flag, error, data
  logic [9:0]  notes[$];
  logic [9:0]  nt;
  int          fails = 0;
  int          checks = 0;
  logic [7:0]  r;

  always #25 clk = ~clk;

  ppe_port #(.ADDR_W(6)) DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .parallel_data_lines_i(lines_i),
    .parallel_data_lines_o(lines_o), .parallel_data_lines_oe(oe), .strobe_pin_n(strobe_n),
    .feed_pin_n(feed_n), .select_pin_n(select_n), .reinit_pin_n(reinit_n),
    .busy_pin(busy), .ack_pin_n(ack_n), .paper_out(paper), .printer_online(online),
    .fault_pin_n(fault_n));

  ppe_periph PEER (.clk(clk), .stall(stall), .force_busy(force_busy), .dly(dly),
    .rd_byte(rd_byte), .sts(sts), .strobe_pin_n(strobe_n), .feed_pin_n(feed_n),
    .select_pin_n(select_n), .lines_o(lines_o), .lines_oe(oe), .busy_pin(busy),
    .ack_pin_n(ack_n), .paper_out(paper), .printer_online(online),
    .fault_pin_n(fault_n), .lines_i(lines_i), .wr_seen(wr_seen));

  ////////////////////////////////////////////////////////////////
  // Compare tasks and closing
  task automatic cmp_bus(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected answer at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected pins at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // APB transfer; the note is queued for the monitor
  task automatic apb(input logic [3:0] idx, input logic w, input logic [7:0] d,
                     input logic [7:0] e, input logic er, input logic cd);
    notes.push_back({cd, er, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic er);
    apb(idx, 1'b1, d, 8'h00, er, 1'b0);
  endtask

  task automatic rd(input logic [3:0] idx, input logic [7:0] e, input logic er);
    apb(idx, 1'b0, 8'h00, e, er, 1'b1);
  endtask

  // Monitor takes the oldest note at each answer
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt[9]) cmp_bus({pslverr, prdata}, {nt[8], 24'h0, nt[7:0]});
      else cmp_bus({pslverr, 32'h0}, {nt[8], 32'h0});
    end
  end

  // Watchdog against a hang
  initial begin
    #(50 * 20000);
    fails++;
    test_done;
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h4aab));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ppe_pkg::IDX_CONTROL, 8'he0, 1'b0);
    cmp_pin({4'h0, oe, strobe_n, feed_n, select_n}, 8'h0f);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom());
      force_busy <= r[4];
      sts <= r[3:0];
      repeat (4) @(posedge clk);
      rd(ppe_pkg::IDX_STATUS, {r[4:0], 3'b110}, 1'b0);
    end
    force_busy <= 1'b0;
    sts <= 4'hb;
    for (int i = 0; i < 3; i++) begin
      r = 8'($urandom());
      wr(ppe_pkg::IDX_DATA, r, 1'b0);
      rd(ppe_pkg::IDX_DATA, r, 1'b0);
      cmp_pin(lines_o, r);
      r = 8'($urandom());
      wr(ppe_pkg::IDX_CONTROL, r, 1'b0);
      rd(ppe_pkg::IDX_CONTROL, {3'b111, r[4:0]}, 1'b0);
      cmp_pin({3'h0, oe, ~strobe_n, ~feed_n, reinit_n, ~select_n}, {4'h1, r[0], r[1], r[2], r[3]});
    end
    wr(ppe_pkg::IDX_CONTROL, 8'h00, 1'b0);
    for (int i = 3; i < 8; i++) rd(4'(i), 8'h00, 1'b1);
    rd(4'hb, 8'h00, 1'b1);
    $display("test standard done");
    for (int m = 0; m < 4; m++) begin
      wr(ppe_pkg::IDX_MODE, 8'(m), 1'b0);
      wr(ppe_pkg::IDX_CONTROL, 8'h20, 1'b0);
      repeat (2) @(posedge clk);
      cmp_pin({7'h0, oe}, {7'h0, m == 0});
    end
    wr(ppe_pkg::IDX_CONTROL, 8'h00, 1'b0);
    wr(ppe_pkg::IDX_MODE, 8'h02, 1'b0);
    for (int i = 0; i < 5; i++) begin
      r = 8'($urandom());
      dly <= 4'($urandom_range(3, 0));
      wr(4'(i + 3), r, 1'b0);
      cmp_pin(wr_seen, r);
      rd_byte <= ~r;
      rd(4'(i + 3), ~r, 1'b0);
    end
    $display("test enhanced done");
    rd(ppe_pkg::IDX_IRQ_STAT, 8'h04, 1'b0);
    rd(ppe_pkg::IDX_MODE, 8'h02, 1'b0);
    wr(ppe_pkg::IDX_IRQ_STAT, 8'h07, 1'b0);
    force_busy <= 1'b1;
    stall <= 1'b1;
    fork
      wr(ppe_pkg::IDX_EADDR, 8'h5a, 1'b1);
      begin
        repeat (8) @(posedge clk);
        cmp_pin({5'h0, strobe_n, feed_n, select_n}, 8'h07);
        force_busy <= 1'b0;
        repeat (8) @(posedge clk);
        cmp_pin({5'h0, strobe_n, feed_n, select_n}, 8'h02);
      end
    join
    stall <= 1'b0;
    cmp_pin({7'h0, irq}, 8'h00);
    rd(ppe_pkg::IDX_STATUS, 8'h5f, 1'b0);
    wr(ppe_pkg::IDX_STATUS, 8'h00, 1'b0);
    rd(ppe_pkg::IDX_STATUS, 8'h5f, 1'b0);
    wr(ppe_pkg::IDX_STATUS, 8'h01, 1'b0);
    rd(ppe_pkg::IDX_STATUS, 8'h5e, 1'b0);
    wr(ppe_pkg::IDX_IRQ_MASK, 8'h02, 1'b0);
    repeat (2) @(posedge clk);
    cmp_pin({7'h0, irq}, 8'h01);
    wr(ppe_pkg::IDX_IRQ_STAT, 8'h02, 1'b0);
    repeat (2) @(posedge clk);
    cmp_pin({7'h0, irq}, 8'h00);
    $display("test timeout done");
    wr(ppe_pkg::IDX_IRQ_STAT, 8'h07, 1'b0);
    wr(ppe_pkg::IDX_IRQ_MASK, 8'h01, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr(ppe_pkg::IDX_CONTROL, {3'h0, 1'(k), 4'h0}, 1'b0);
      sts[3] <= 1'b0;
      repeat (5) @(posedge clk);
      sts[3] <= 1'b1;
      repeat (6) @(posedge clk);
      cmp_pin({7'h0, irq}, {7'h0, 1'(k)});
    end
    $display("test ack done");
    test_done;
  end
endmodule
